// >>> fosr_host.sv
// host controller: AHB-Lite registers, flash cycles, status polling
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fosr_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output fosr_pkg::fosr_pins_t flashPins,
  input wire logic [7:0] dqIn,
  input wire logic ready_busy_n
);
  import fosr_pkg::*;
  typedef enum logic [2:0] {sIdle, sAccess, sConfirm, sCheck, sAbort} fosr_st_t;

  // ==========================================================================
  // declarations
  fosr_st_t state_r;
  logic [2:0] op_r;
  logic [19:0] addr_r;
  logic [7:0] wdata_r;
  logic [15:0] eraseMask_r;
  logic susp_r;
  logic done_r;
  logic fail_r;
  logic refused_r;
  logic timerBit_r;
  logic tog2_r;
  logic haveFirst_r;
  logic [7:0] prev_r;
  logic [7:0] last_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic cycStart_r;
  logic cycWrite_r;
  logic [19:0] cycAddr_r;
  logic [7:0] cycWdata_r;
  logic cycDone;
  logic [7:0] cycRdata;
  logic [7:0] dqSync;
  logic rdySync;
  logic busy;
  logic addrPhase;
  logic cmdWr;
  logic refuse;
  logic isPoll;
  logic expBit;
  logic [2:0] newOp;

  // ==========================================================================
  // pin synchronisers and the cycle engine
  fosr_sync #(.WIDTH(8)) u_dqSync (
    .clk(clk),
    .rst_n(rst_n),
    .din(dqIn),
    .dout(dqSync)
  );

  fosr_sync #(.WIDTH(1)) u_rdySync (
    .clk(clk),
    .rst_n(rst_n),
    .din(ready_busy_n),
    .dout(rdySync)
  );

  fosr_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(cycStart_r),
    .isWrite(cycWrite_r),
    .addr(cycAddr_r),
    .wdata(cycWdata_r),
    .dqSync(dqSync),
    .done(cycDone),
    .rdata(cycRdata),
    .pins(flashPins)
  );

  // ==========================================================================
  // decode helpers
  function automatic logic [31:0] regRead(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    case (a)
      REG_CMD: v[2:0] = op_r;
      REG_ADDR: v[19:0] = addr_r;
      REG_WDATA: v[7:0] = wdata_r;
      REG_STATUS: begin
        v[ST_BUSY] = busy;
        v[ST_DONE] = done_r;
        v[ST_FAIL] = fail_r;
        v[ST_REFUSED] = refused_r;
        v[ST_READY] = rdySync; // ready/busy pin level, high when idle [R14]
        v[ST_TIMER] = timerBit_r;
        v[ST_TOG2] = tog2_r;
        v[ST_SUSP] = susp_r;
        v[ST_DATA +: 8] = last_r;
      end
      REG_SUSP: begin
        v[0] = susp_r;
        v[SUSP_MASK +: 16] = eraseMask_r;
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : regRead

  assign busy = (state_r != sIdle);
  assign addrPhase = hsel && hready && htrans[1];
  assign newOp = hwdata[2:0];
  assign cmdWr = wrPend_r && (wrAddr_r == REG_CMD) && !busy;
  // program writes into sectors marked for erase are refused while suspended [R19]
  assign refuse = (newOp == OP_WRITE) && susp_r && eraseMask_r[addr_r[19:16]];
  assign isPoll = (op_r == OP_POLLPROG) || (op_r == OP_POLLERASE);
  // final polling value: programmed bit, or 1 for erase done or suspended [R03] [R06]
  assign expBit = (op_r == OP_POLLPROG) ? wdata_r[DQ_POLL] : 1'b1;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // AHB-Lite slave: address phase capture and read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= regRead(haddr[7:0]);
      end
    end
  end

  // ==========================================================================
  // software registers, frozen while an operation runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= ADDR_RST;
      wdata_r <= DATA_RST;
      eraseMask_r <= MASK_RST;
      susp_r <= 1'b0;
    end else if (wrPend_r && !busy) begin
      case (wrAddr_r)
        REG_ADDR: addr_r <= hwdata[19:0];
        REG_WDATA: wdata_r <= hwdata[7:0];
        REG_SUSP: begin
          susp_r <= hwdata[0];
          eraseMask_r <= hwdata[SUSP_MASK +: 16];
        end
        default: addr_r <= addr_r;
      endcase
    end
  end

  // ==========================================================================
  // operation sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sIdle;
      op_r <= OP_READ;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      refused_r <= 1'b0;
      timerBit_r <= 1'b0;
      tog2_r <= 1'b0;
      haveFirst_r <= 1'b0;
      prev_r <= 8'h00;
      last_r <= 8'h00;
      cycStart_r <= 1'b0;
      cycWrite_r <= 1'b0;
      cycAddr_r <= ADDR_RST;
      cycWdata_r <= DATA_RST;
    end else begin
      cycStart_r <= 1'b0;
      if (cycDone) begin
        prev_r <= cycRdata;
        timerBit_r <= cycRdata[DQ_TIMER]; // erase window expired, erasing now [R16] [R21]
        if (haveFirst_r) begin
          tog2_r <= cycRdata[DQ_TOG2] ^ prev_r[DQ_TOG2]; // sector selected for erase [R17] [R22]
        end
      end
      case (state_r)
        sIdle: begin
          if (cmdWr) begin
            op_r <= newOp;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            refused_r <= refuse;
            haveFirst_r <= 1'b0;
            tog2_r <= 1'b0;
            if (!refuse) begin // [R19]
              state_r <= sAccess;
              cycStart_r <= 1'b1;
              cycWrite_r <= (newOp == OP_WRITE) || (newOp == OP_RESET);
              cycWdata_r <= (newOp == OP_RESET) ? CMD_RESET : wdata_r; // leaves ID mode [R01]
              // group number on top bits, low byte selects protection code [R02]
              cycAddr_r <= (newOp == OP_PROT) ? {addr_r[19:17], 9'h000, PROT_LOW} : addr_r;
            end
          end
        end
        sAccess: begin
          if (cycDone) begin
            if (isPoll) begin
              // polls stay at the program or erase address [R04] [R20]
              cycStart_r <= 1'b1;
              if (cycRdata[DQ_POLL] == expBit) begin
                state_r <= sConfirm; // one more read for all eight bits [R09]
              end else if (cycRdata[DQ_FAIL]) begin
                state_r <= sCheck; // timeout bit seen, recheck polling bit [R15]
              end
            end else if (op_r == OP_TOGGLE) begin
              haveFirst_r <= 1'b1;
              if (haveFirst_r && (cycRdata[DQ_TOG1] == prev_r[DQ_TOG1])) begin
                // toggling stopped: done, suspended, or protected target timed out [R10] [R12] [R11]
                state_r <= sIdle;
                done_r <= 1'b1;
                last_r <= cycRdata;
              end else begin
                cycStart_r <= 1'b1;
                if (haveFirst_r && cycRdata[DQ_FAIL]) begin
                  state_r <= sCheck; // [R15]
                end
              end
            end else begin
              state_r <= sIdle;
              done_r <= 1'b1;
              last_r <= cycRdata;
            end
          end
        end
        sCheck: begin
          if (cycDone) begin
            if (isPoll ? (cycRdata[DQ_POLL] == expBit) : (cycRdata[DQ_TOG1] == prev_r[DQ_TOG1])) begin
              state_r <= isPoll ? sConfirm : sIdle;
              cycStart_r <= isPoll;
              done_r <= !isPoll;
              last_r <= cycRdata;
            end else begin
              // failed: bring the device back to read mode [R23]
              state_r <= sAbort;
              fail_r <= 1'b1;
              last_r <= cycRdata;
              cycStart_r <= 1'b1;
              cycWrite_r <= 1'b1;
              cycWdata_r <= CMD_RESET;
            end
          end
        end
        sConfirm: begin
          if (cycDone) begin
            state_r <= sIdle;
            done_r <= 1'b1;
            last_r <= cycRdata; // [R09]
          end
        end
        sAbort: begin
          if (cycDone) begin
            state_r <= sIdle;
            done_r <= 1'b1;
          end
        end
        default: state_r <= sIdle;
      endcase
    end
  end

  // ==========================================================================
  // checks
  start_busy_a: assert property (@(posedge clk) disable iff (!rst_n) cmdWr && !refuse |=> busy && cycStart_r)
    else $error("accepted command did not start");
  refuse_susp_a: assert property (@(posedge clk) disable iff (!rst_n) cmdWr && refuse |=> refused_r && !busy) // [R19]
    else $error("write to suspended erase sector not refused");
  confirm_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R09]
    state_r == sAccess && cycDone && isPoll && cycRdata[DQ_POLL] == expBit |=> state_r == sConfirm && cycStart_r && !cycWrite_r)
    else $error("no confirming read after polling bit settled");
  abort_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
    state_r == sCheck && cycDone && isPoll && cycRdata[DQ_POLL] != expBit |=> fail_r && cycWrite_r && cycWdata_r == CMD_RESET)
    else $error("failure not followed by reset command");
  prot_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // [R02]
    cmdWr && newOp == OP_PROT |=> cycAddr_r[7:0] == PROT_LOW && cycAddr_r[19:17] == $past(addr_r[19:17]))
    else $error("protection read address wrong");
  confirm_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == sConfirm && cycDone |=> !busy && done_r && last_r == $past(cycRdata))
    else $error("confirm read did not finish operation");
endmodule : fosr_host

// >>> fosr_pkg.sv
// constants, pin bundle and op codes for the flash status host controller
//
// Operation
// (R01) Host leaves identification mode with Reset; device returns to read or suspend.
// (R02) ID mode read at low address 0x02 reports protection of group on A[19:17].
// (R03) Polling bit reads inverted programmed bit while programming, true value after.
// (R04) Host polls for program status at the program address only.
// (R05) Program to protected sector shows polling for about 2 us, then array data.
// (R06) Erase polling bit reads 0 in erasing sector, 1 when done or suspended.
// (R07) All-protected erase keeps polling active about 100 us, then array read.
// (R08) Mixed erase selection erases only unprotected sectors, skips protected ones.
// (R09) After polling bit reaches final value, host reads once more for all bits.
// (R10) Toggle bit one changes per read during programming, stops when done.
// (R11) Program to protected sector toggles bit one about 2 us, then array reads.
// (R12) Toggle bit one alternates during erase, stops on completion or suspend.
// (R13) Toggle bit one valid after final write strobe; chip or output strobe reads.
// (R14) Open-drain ready/busy low while programming or erasing, high when ready.
// (R15) Timeout failure bit becomes 1 when program or erase exceeds limit.
// (R16) Erase timer bit reads 1 after 50 us window, meaningless for chip erase.
// (R17) Suspended-sector read: polling 1, toggle one still, fail 0, toggle two alternates.
// (R18) In suspend, reads outside erase sectors return array data, ready high.
// (R19) While suspended, host programs only sectors not marked for erasure.
// (R20) Host presents a valid address on every status read.
// (R21) Active sector erase: toggle two alternates, timer bit 1, ready/busy low.
// (R22) Toggle bit two changes per read inside sectors selected for erasure.
// (R23) After timeout failure bit sets, host issues Read/Reset command.
package fosr_pkg;
  // ==========================================================================
  // widths
  localparam int ADDR_W = 20;
  localparam int DQ_W = 8;
  // ==========================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_SUSP = 8'h10;
  // ==========================================================================
  // operation codes written to the command register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_RESET = 3'h2;
  localparam logic [2:0] OP_PROT = 3'h3;
  localparam logic [2:0] OP_POLLPROG = 3'h4;
  localparam logic [2:0] OP_POLLERASE = 3'h5;
  localparam logic [2:0] OP_TOGGLE = 3'h6;
  // ==========================================================================
  // flash data values and status bit positions on the data bus
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] PROT_LOW = 8'h02;
  localparam int DQ_POLL = 7;
  localparam int DQ_TOG1 = 6;
  localparam int DQ_FAIL = 5;
  localparam int DQ_TIMER = 3;
  localparam int DQ_TOG2 = 2;
  // ==========================================================================
  // status and suspend register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_READY = 4;
  localparam int ST_TIMER = 5;
  localparam int ST_TOG2 = 6;
  localparam int ST_SUSP = 7;
  localparam int ST_DATA = 8;
  localparam int SUSP_MASK = 16;
  // ==========================================================================
  // reset values
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // ==========================================================================
  // strobe timing in cycles
  localparam int CLK_NS = 50;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int SYNC_STAGES = 2;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
  localparam int WP_RAW = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (WP_RAW < 1) ? 1 : WP_RAW;
  // ==========================================================================
  // flash pins driven by the host
  typedef struct packed {
    logic ceN;
    logic weN;
    logic oeN;
    logic [19:0] addr;
    logic [7:0] dqOut;
    logic dqOe;
  } fosr_pins_t;
endpackage : fosr_pkg

// >>> fosr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fosr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import fosr_pkg::*;
  logic [WIDTH-1:0] stage1_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      dout <= '0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule : fosr_sync

// >>> fosr_cycle.sv
// one flash bus cycle: read or write with chip, output and write strobes
`timescale 1ns/1ps
module fosr_cycle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] dqSync,
  output logic done,
  output logic [7:0] rdata,
  output fosr_pkg::fosr_pins_t pins
);
  import fosr_pkg::*;
  typedef enum logic [1:0] {cIdle, cSetup, cStrobe, cHold} fosr_cst_t;
  fosr_cst_t state_r;
  logic write_r;
  logic [2:0] cnt_r;

  // strobe sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cIdle;
      write_r <= 1'b0;
      cnt_r <= 3'h0;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: 20'h00000, dqOut: 8'h00, dqOe: 1'b0};
    end else begin
      done <= 1'b0;
      case (state_r)
        cIdle: begin
          if (start) begin
            write_r <= isWrite;
            pins.ceN <= 1'b0;
            pins.addr <= addr; // address set with chip strobe, stable before output or write strobe [R20]
            pins.dqOut <= wdata;
            pins.dqOe <= isWrite;
            state_r <= cSetup;
          end
        end
        cSetup: begin
          if (write_r) begin
            pins.weN <= 1'b0;
            cnt_r <= 3'(WP_CYC - 1);
          end else begin
            pins.oeN <= 1'b0; // output strobe drives the status read [R13]
            cnt_r <= 3'(RD_CYC - 1);
          end
          state_r <= cStrobe;
        end
        cStrobe: begin
          if (cnt_r == 3'h0) begin
            pins.weN <= 1'b1;
            pins.oeN <= 1'b1;
            if (!write_r) begin
              rdata <= dqSync;
            end
            state_r <= cHold;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        cHold: begin
          pins.ceN <= 1'b1;
          pins.dqOe <= 1'b0;
          done <= 1'b1;
          state_r <= cIdle;
        end
        default: state_r <= cIdle;
      endcase
    end
  end

  strobe_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n) !(!pins.oeN && !pins.weN))
    else $error("output and write strobes low together");
  no_contention_a: assert property (@(posedge clk) disable iff (!rst_n) pins.dqOe |-> pins.oeN)
    else $error("host drives data while output strobe low");
  read_width_a: assert property (@(posedge clk) disable iff (!rst_n) $fell(pins.oeN) |-> !pins.oeN[*4] ##1 pins.oeN) // [R20]
    else $error("read strobe not four cycles");
  write_width_a: assert property (@(posedge clk) disable iff (!rst_n) $fell(pins.weN) |=> pins.weN && pins.dqOe)
    else $error("write strobe width or data hold wrong");
  done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) done |=> !done && pins.ceN)
    else $error("done not a single pulse");
endmodule : fosr_cycle

// >>> fosr_flash_model.sv
// behavioural flash device with status bits, suspend, id mode
`timescale 1ns/1ps
module fosr_flash_model #(
  parameter int PROG_NS = 4000,
  parameter int PROT_NS = 2000,
  parameter int WIN_NS = 50000,
  parameter int ERASE_NS = 30000,
  parameter int PROTE_NS = 100000,
  parameter logic [2:0] PROT_GRP = 3'h7
) (
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic [19:0] addr,
  input wire logic [7:0] dqHost,
  input wire logic failMode,
  output logic [7:0] dq,
  output logic busyLow
);
  // modes: 0 read, 1 program, 2 erase, 3 suspended, 4 id
  int mode = 0;
  int retMode = 0;
  time endT = 0, t0 = 0, suspT = 0;
  logic armed = 0, stuck = 0, fail = 0, progBit = 0, tog1 = 0, tog2 = 0, drive = 0;
  logic [19:0] progA = 0;
  logic [15:0] eraseMask = 0;
  logic [7:0] out = 0;
  logic [7:0] mem [logic [19:0]];
  function automatic logic [7:0] memRd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : memRd
  // ==========================================================================
  // command writes on the rising write strobe
  always @(posedge weN) if (ceN === 1'b0) begin
    if (armed) begin
      armed = 1'b0;
      progA = addr;
      progBit = dqHost[7];
      stuck = failMode;
      retMode = mode;
      if (addr[19:17] != PROT_GRP) mem[addr] = dqHost;
      endT = $time + ((addr[19:17] == PROT_GRP) ? PROT_NS : PROG_NS);
      mode = 1;
    end else case (dqHost)
      8'ha0: armed = (mode == 0 || mode == 3);
      8'hf0: if (fail || mode == 4) begin
        mode = retMode;
        fail = 1'b0;
        stuck = 1'b0;
      end
      8'h90: if (mode == 0 || mode == 3) begin
        retMode = mode;
        mode = 4;
      end
      8'hb0: if (mode == 2) begin
        mode = 3;
        suspT = $time;
      end
      8'h30: if (mode == 3) begin
        endT = endT + ($time - suspT);
        mode = 2;
      end else if (mode == 0) begin
        eraseMask = 16'h1 << addr[19:16];
        t0 = $time;
        endT = $time + ((addr[19:17] == PROT_GRP) ? PROTE_NS : WIN_NS + ERASE_NS);
        mode = 2;
      end
      default: ;
    endcase
  end
  // completion and timeout of the embedded algorithm
  always #50 begin
    if ((mode == 1 || mode == 2) && $time >= endT) begin
      if (stuck) fail = 1'b1;
      else begin
        // only unprotected selected sectors lose their data
        if (mode == 2) foreach (mem[k]) if (eraseMask[k[19:16]] && k[19:17] != PROT_GRP) mem[k] = 8'hff;
        mode = (mode == 1) ? retMode : 0;
      end
    end
  end
  // ==========================================================================
  // status or array data on each output-strobe read
  always @(negedge oeN) if (ceN === 1'b0) begin
    case (mode)
      1: begin
        tog1 = ~tog1;
        out = {(addr == progA) ? ~progBit : 1'b0, tog1, fail, 5'h0};
      end
      2: begin
        tog1 = ~tog1;
        if (eraseMask[addr[19:16]]) tog2 = ~tog2;
        out = {1'b0, tog1, fail, 1'b0, $time >= t0 + WIN_NS, tog2, 2'h0};
      end
      3: if (eraseMask[addr[19:16]]) begin
        tog2 = ~tog2;
        out = {1'b1, tog1, 1'b0, 2'h0, tog2, 2'h0};
      end else out = memRd(addr);
      4: out = (addr[7:0] == 8'h02) ? {7'h0, addr[19:17] == PROT_GRP} : 8'h00;
      default: out = memRd(addr);
    endcase
    drive = 1'b1;
  end
  always @(posedge oeN or posedge ceN) drive = 1'b0;
  // released bus shows the inverse of the last byte
  assign dq = drive ? out : ~out;
  assign busyLow = (mode == 1) || (mode == 2);
endmodule : fosr_flash_model

// >>> tb.sv
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
  import fosr_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, failMode = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, st;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, busyLow;
  logic [7:0] flashDq;
  fosr_pins_t pins;
  int n_mismatch = 0, cmp_count = 0;
  time t;
  wire logic [7:0] dqIn = pins.dqOe ? pins.dqOut : flashDq;
  wire logic ready_busy_n = busyLow ? 1'b0 : 1'b1; // pull-up
  always #25 clk = ~clk;
  fosr_host i_fosr_host (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .flashPins(pins), .dqIn(dqIn), .ready_busy_n(ready_busy_n));
  fosr_flash_model i_fosr_flash_model (.ceN(pins.ceN), .weN(pins.weN), .oeN(pins.oeN),
    .addr(pins.addr), .dqHost(pins.dqOut), .failMode(failMode), .dq(flashDq), .busyLow(busyLow));
  // ==========================================================================
  // bus tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin n_mismatch++; summarize(); end
      @(posedge clk);
    end
  endtask : waitRdy
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitRdy();
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  // one controller operation, then status polled until idle
  task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(REG_ADDR, {12'h0, a});
    wr(REG_WDATA, {24'h0, d});
    wr(REG_CMD, {29'h0, op});
    do begin
      xfer(1'b0, REG_STATUS, 32'h0, st);
      n++;
      if (n > 3000) begin n_mismatch++; summarize(); end
    end while (st[ST_BUSY] !== 1'b0);
  endtask : run
  task automatic prog(input logic [19:0] a, input logic [7:0] d);
    run(OP_WRITE, a, 8'ha0);
    run(OP_WRITE, a, d);
  endtask : prog
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask : endTest
  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // let the pin synchronisers carry the idle ready level through
    repeat (3) @(posedge clk);
    xfer(1'b0, REG_STATUS, 32'h0, st);
    `CHK({hresp, st}, {1'b0, 32'h00000010})
    xfer(1'b0, 8'h20, 32'h0, st);
    `CHK(st, 32'h0)
    endTest("reset");
    // program, then poll at the program address
    prog(20'h20005, 8'h5a);
    `CHK(st[ST_READY], 1'b0)
    run(OP_POLLPROG, 20'h20005, 8'h5a);
    `CHK(st[15:8], 8'h5a)
    `CHK(st[2:0], 3'b010)
    endTest("program");
    // toggle polling at an unrelated address
    prog(20'h20006, 8'h3c);
    run(OP_TOGGLE, 20'h40000, 8'h00);
    `CHK(st[15:8], 8'hff)
    run(OP_READ, 20'h20006, 8'h00);
    `CHK(st[15:8], 8'h3c)
    endTest("toggle");
    // program into a protected group leaves the array alone
    prog(20'he0001, 8'h00);
    run(OP_TOGGLE, 20'he0001, 8'h00);
    `CHK(st[15:8], 8'hff)
    `CHK(st[2:1], 2'b01)
    endTest("protected program");
    // sector erase with suspend, refusal and resume
    run(OP_WRITE, 20'h10000, 8'h30);
    run(OP_READ, 20'h10000, 8'h00);
    `CHK({st[15], st[11]}, 2'b00)
    run(OP_WRITE, 20'h10000, 8'hb0);
    run(OP_READ, 20'h10000, 8'h00);
    // toggle poll: two reads in one operation, so the DQ2 comparison is made
    run(OP_TOGGLE, 20'h10000, 8'h00);
    `CHK({st[15], st[13]}, 2'b10)
    `CHK(st[ST_TOG2], 1'b1)
    `CHK(st[ST_READY], 1'b1)
    run(OP_READ, 20'h20005, 8'h00);
    `CHK(st[15:8], 8'h5a)
    wr(REG_SUSP, 32'h00020001);
    run(OP_WRITE, 20'h10009, 8'ha0);
    `CHK(st[ST_REFUSED:ST_DONE], 3'b100)
    wr(REG_SUSP, 32'h0);
    run(OP_WRITE, 20'h10000, 8'h30);
    repeat (1100) @(posedge clk);
    run(OP_READ, 20'h10000, 8'h00);
    `CHK({st[15], st[11]}, 2'b01)
    `CHK(st[ST_READY], 1'b0)
    run(OP_POLLERASE, 20'h10000, 8'h00);
    `CHK(st[15:8], 8'hff)
    `CHK(st[2:1], 2'b01)
    endTest("erase suspend");
    // erase of a protected group only keeps polling busy
    t = $time;
    run(OP_WRITE, 20'he0000, 8'h30);
    run(OP_TOGGLE, 20'he0000, 8'h00);
    `CHK(($time - t) > 64'd99000, 1'b1)
    `CHK(st[2:1], 2'b01)
    endTest("protected erase");
    // identification mode and leaving it
    run(OP_WRITE, 20'h00000, 8'h90);
    run(OP_PROT, 20'he0000, 8'h00);
    `CHK(st[15:8], 8'h01)
    run(OP_PROT, 20'h20000, 8'h00);
    `CHK(st[15:8], 8'h00)
    run(OP_RESET, 20'h00000, 8'h00);
    run(OP_READ, 20'h20005, 8'h00);
    `CHK(st[15:8], 8'h5a)
    endTest("identification");
    // program that overruns its time limit
    failMode <= 1'b1;
    prog(20'h30000, 8'h77);
    failMode <= 1'b0;
    run(OP_POLLPROG, 20'h30000, 8'h77);
    `CHK(st[2:1], 2'b11)
    run(OP_READ, 20'h30000, 8'h00);
    `CHK(st[ST_READY], 1'b1)
    endTest("timeout");
    summarize();
  end
endmodule : tb
